// [design/ivc_pkg.sv]
// ivc_pkg: constants, register map and carrier types of the interrupt vector controller
// assumes: one system clock, a plain register port and a processor core that
// acknowledges the vector it is shown
package ivc_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int NUM_SRC       = 246;   // interrupt vector slots
   localparam int NUM_TRAP      = 8;     // exception and trap slots
   localparam int PRIO_W        = 3;     // user priority field width
   localparam int LEVEL_W       = 4;     // presented level, traps above user
   localparam int VEC_W         = 8;     // vector number width
   localparam int ADDR_W        = 24;    // program address width
   localparam int RA_W          = 8;     // register address width
   localparam int RD_W          = 16;    // register data width
   localparam int BSL_W         = 13;    // boot segment limit width
   localparam int PAGE_SHIFT    = 11;    // boot segment page size, log2 of words

   // ---------------------------------------------------------------
   // vector table layout
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] PRIMARY_TABLE_START = 24'h000004;   // first trap vector
   localparam logic [ADDR_W-1:0] ALT_TRAP_OFFSET     = 24'h000004;   // first trap in alt table
   localparam logic [ADDR_W-1:0] IRQ0_OFFSET         = 24'h000014;   // interrupt vector 0
   localparam logic [ADDR_W-1:0] LAST_IRQ_OFFSET     = 24'h0001fe;   // interrupt vector 245
   localparam logic [VEC_W-1:0]  FIRST_IRQ_VEC       = 8'h08;        // vector number of irq 0
   localparam logic [LEVEL_W-1:0] TRAP_LEVEL         = 4'h8;         // above every user level

   // ---------------------------------------------------------------
   // register map (word index on the register port)
   // ---------------------------------------------------------------
   localparam logic [RA_W-1:0] FLAG_BASE   = 8'h00;   // pending_flag_word_zero onward, 16 words
   localparam logic [RA_W-1:0] ENABLE_BASE = 8'h10;   // enable_word_zero onward, 16 words
   localparam logic [RA_W-1:0] PRIO_BASE   = 8'h40;   // priority_word_zero onward, 62 words
   localparam logic [RA_W-1:0] CTRL2_ADDR  = 8'h80;   // interrupt_control_two
   localparam logic [RA_W-1:0] BOOT_SEGMENT_LIMIT_ADDR  = 8'h81;   // boot_segment_limit
   localparam logic [RA_W-1:0] STAT_ADDR   = 8'h82;   // presented request status
   localparam logic [RA_W-1:0] IPL_ADDR    = 8'h83;   // core priority threshold
   localparam int FLAG_WORDS = 16;
   localparam int PRIO_WORDS = 62;
   localparam int PRIO_PER_WORD = 4;

   // field positions
   localparam int CTRL2_ALT_EN_BIT = 15;   // alt_table_enable
   localparam int STAT_REQ_BIT     = 15;   // request presented

   // reset values
   localparam logic [RD_W-1:0]   CTRL2_RST = 16'h0000;
   localparam logic [BSL_W-1:0]  BOOT_SEGMENT_LIMIT_RST = 13'h0000;
   localparam logic [PRIO_W-1:0] PRIO_RST  = 3'h4;
   localparam logic [PRIO_W-1:0] IPL_RST   = 3'h0;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed
   {
      logic             wr;     // write strobe
      logic             rd;     // read strobe
      logic [RA_W-1:0]  addr;   // word index
      logic [RD_W-1:0]  wdata;  // write data
   } ivc_bus_t;

   typedef struct packed
   {
      logic               req;    // single request to the core
      logic [LEVEL_W-1:0] level;  // winner's level, trap level for traps
      logic [VEC_W-1:0]   vec;    // winner's vector number
      logic [ADDR_W-1:0]  addr;   // program address of the table entry
   } ivc_cpu_t;

endpackage

// [design/ivc_arbiter.sv]
// ivc_arbiter: picks the highest level request, lowest index on a tie
// assumes: requests already gated by flag, enable and presence; level 0 never wins
`timescale 1ns/100ps
module ivc_arbiter
   import ivc_pkg::*;
#(
   parameter int N = NUM_SRC
)
(
   // requests
   input  wire logic [N-1:0]        req,
   input  wire logic [N*PRIO_W-1:0] prio,
   // winner
   output logic                     valid,
   output logic [VEC_W-1:0]         idx,
   output logic [PRIO_W-1:0]        level
);

   // ---------------------------------------------------------------
   // scan from the top so a lower index with equal level takes over
   // ---------------------------------------------------------------
   always_comb
   begin
      valid = 1'b0;
      idx   = '0;
      level = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         // higher user level wins, equal level goes to the lower slot
         if (req[i] && (prio[i*PRIO_W +: PRIO_W] != '0) &&
             (prio[i*PRIO_W +: PRIO_W] >= level))          // [R3] [R5] [R11]
         begin
            valid = 1'b1;
            idx   = VEC_W'(i);
            level = prio[i*PRIO_W +: PRIO_W];
         end
      end
   end

endmodule

// [design/ivc_top.sv]
// ivc_top: interrupt vector controller, register file, arbitration and vectoring
// assumes: peripherals and traps drive levels on ref_clk; the core pulses ack for
// the vector it was shown and reports its current priority through a register
//
// Behaviour
// R1 - many requests merge into one core request
// R2 - 246 slots, absent slots never request
// R3 - seven user levels, higher level wins
// R4 - up to eight exception and trap sources
// R5 - same level resolved by fixed order
// R6 - entry and return latency independent of source
// R7 - software can set any pending flag
// R8 - primary table starts at program address 4
// R9 - traps cannot be masked
// R10 - entry holds 24-bit service routine address
// R11 - lower table position wins within level
// R12 - alternate table needs segment, enable, config
// R13 - alternate table base is last boot page
// R14 - alternate trap offsets 0x4 through 0x10
// R15 - vector n at 0x14 plus two times n
// R16 - each source has flag, enable, priority field
// R17 - present vector number and level with request
`timescale 1ns/100ps
module ivc_top
   import ivc_pkg::*;
#(
   parameter logic [NUM_SRC-1:0]  SRC_PRESENT  = {NUM_SRC{1'b1}},   // implemented slots
   parameter logic [NUM_TRAP-1:0] TRAP_PRESENT = 8'h7f               // slot 7 reserved
)
(
   // clock, reset, enable
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                ce,
   // register port
   input  wire ivc_bus_t            bus,
   output logic [RD_W-1:0]          rdata,
   // peripheral and trap requests
   input  wire logic [NUM_SRC-1:0]  irq_in,
   input  wire logic [NUM_TRAP-1:0] trap_in,
   // boot configuration
   input  wire logic                boot_segment_defined,
   input  wire logic                alt_table_config_select,
   // processor core
   output ivc_cpu_t                 cpu,
   input  wire logic                cpu_ack
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [NUM_SRC-1:0]      flag_q;                 // pending flags
   logic [NUM_SRC-1:0]      flag_d;                 // next pending flags
   logic [NUM_SRC-1:0]      en_q;                   // enables
   logic [NUM_SRC*PRIO_W-1:0] prio_q;               // priority fields, packed
   logic [NUM_TRAP-1:0]     trap_q;                 // latched traps
   logic [RD_W-1:0]         ctrl2_q;                // interrupt_control_two
   logic [BSL_W-1:0]        boot_segment_limit_q;                // boot_segment_limit
   logic [PRIO_W-1:0]       ipl_q;                  // core threshold
   logic                    ack_take;               // core takes the shown vector now
   ivc_cpu_t                cpu_q;                  // presented request
   logic [RD_W-1:0]         rdata_q;                // read answer

   logic                    arb_valid;              // user winner found
   logic [VEC_W-1:0]        arb_idx;                // user winner slot
   logic [PRIO_W-1:0]       arb_level;              // user winner level
   logic                    trap_any;               // any trap pending
   logic [VEC_W-1:0]        trap_idx;               // lowest trap pending
   logic                    alt_sel;                // alternate table in use
   ivc_cpu_t                cpu_d;                  // next presentation

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // offset of a vector inside either table: trap 0 at 0x4, irq 0 (vec 8) at 0x14
   function automatic logic [ADDR_W-1:0] vec_offset(input logic [VEC_W-1:0] v);
      vec_offset = ALT_TRAP_OFFSET + ADDR_W'({v, 1'b0});      // [R14] [R15]
   endfunction

   // word index inside a register group, or all ones when outside
   function automatic logic [RA_W-1:0] grp_word(input logic [RA_W-1:0] a,
                                                input logic [RA_W-1:0] base,
                                                input int             words);
      logic [RA_W-1:0] d;
      d = a - base;
      grp_word = (a >= base && 32'(d) < words) ? d : '1;
   endfunction

   // ---------------------------------------------------------------
   // arbitration among user interrupts
   // ---------------------------------------------------------------
   ivc_arbiter #(
      .N     (NUM_SRC)
   ) u_arb (
      .req   (flag_q & en_q & SRC_PRESENT),                   // [R1] [R2] [R16]
      .prio  (prio_q),
      .valid (arb_valid),
      .idx   (arb_idx),
      .level (arb_level)
   );

   // lowest-numbered pending trap wins, no enable or threshold applies
   always_comb
   begin
      trap_any = |trap_q;                                     // [R9]
      trap_idx = '0;
      for (int t = NUM_TRAP - 1; t >= 0; t--)
      begin
         if (trap_q[t])
         begin
            trap_idx = VEC_W'(t);                             // [R4] [R11]
         end
      end
   end

   // alternate table only with segment, enable bit and config bit all set
   assign alt_sel = boot_segment_defined && ctrl2_q[CTRL2_ALT_EN_BIT] &&
                    alt_table_config_select;                  // [R12]

   // ---------------------------------------------------------------
   // next presentation: traps first, then user level above threshold
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [ADDR_W-1:0] base;
      // table base: last boot page, or just below the primary start
      base  = alt_sel ? ADDR_W'({boot_segment_limit_q, {PAGE_SHIFT{1'b0}}})
                      : PRIMARY_TABLE_START - ALT_TRAP_OFFSET;   // [R8] [R13]
      cpu_d = '0;
      if (trap_any)
      begin
         cpu_d.req   = 1'b1;                                  // [R9]
         cpu_d.level = TRAP_LEVEL;
         cpu_d.vec   = trap_idx;
      end
      else if (arb_valid && (arb_level > ipl_q))
      begin
         cpu_d.req   = 1'b1;                                  // [R1] [R3]
         cpu_d.level = LEVEL_W'(arb_level);                   // [R17]
         cpu_d.vec   = arb_idx + FIRST_IRQ_VEC;               // [R17]
      end
      // entry address the core fetches the 24-bit routine address from
      cpu_d.addr = base + vec_offset(cpu_d.vec);              // [R10]
      // the core just took the shown vector: show nothing for one cycle
      cpu_d.req = cpu_d.req && !ack_take;                     // [R6]
   end

   // ---------------------------------------------------------------
   // presented request, always one cycle behind arbitration
   // ---------------------------------------------------------------
   // the same single register stage for every source keeps latency fixed
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         cpu_q <= '0;
      end
      else if (ce)
      begin
         cpu_q <= cpu_d;                                      // [R6]
      end
   end

   // a stale vector must not be shown while its flag is being cleared
   assign ack_take = cpu_ack && cpu_q.req;

   assign cpu = cpu_q;

   // ---------------------------------------------------------------
   // trap latches: set by the source, cleared by acceptance
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         trap_q <= '0;
      end
      else if (ce)
      begin
         for (int t = 0; t < NUM_TRAP; t++)
         begin
            // a new trap in the ack cycle wins over the clear
            if (trap_in[t] && TRAP_PRESENT[t])
            begin
               trap_q[t] <= 1'b1;                             // [R4] [R9]
            end
            else if (cpu_ack && cpu_q.req && cpu_q.vec == VEC_W'(t))
            begin
               trap_q[t] <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // pending flags: software write, acceptance clear, hardware set
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [RA_W-1:0] w;
      w      = grp_word(bus.addr, FLAG_BASE, FLAG_WORDS);
      flag_d = flag_q;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         // software writes the whole word, a one raises the request
         if (bus.wr && 32'(w) == i / RD_W)
         begin
            flag_d[i] = bus.wdata[i % RD_W];                  // [R7]
         end
         // acceptance clears the slot the core took
         if (cpu_ack && cpu_q.req && cpu_q.vec == VEC_W'(i + 8))
         begin
            flag_d[i] = 1'b0;
         end
         // hardware set wins over any clear in the same cycle
         if (irq_in[i])
         begin
            flag_d[i] = 1'b1;
         end
         flag_d[i] = flag_d[i] & SRC_PRESENT[i];              // [R2]
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         flag_q <= '0;
      end
      else if (ce)
      begin
         flag_q <= flag_d;                                    // [R16]
      end
   end

   // ---------------------------------------------------------------
   // enables and priority fields
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         en_q   <= '0;
         prio_q <= {NUM_SRC{PRIO_RST}};
      end
      else if (ce && bus.wr)
      begin
         for (int i = 0; i < NUM_SRC; i++)
         begin
            // enable word i/16, bit i%16
            if (32'(grp_word(bus.addr, ENABLE_BASE, FLAG_WORDS)) == i / RD_W)
            begin
               en_q[i] <= bus.wdata[i % RD_W] & SRC_PRESENT[i];   // [R16]
            end
            // priority word i/4, field at bit 4*(i%4)
            if (32'(grp_word(bus.addr, PRIO_BASE, PRIO_WORDS)) == i / PRIO_PER_WORD)
            begin
               prio_q[i*PRIO_W +: PRIO_W] <=
                  bus.wdata[(i % PRIO_PER_WORD)*4 +: PRIO_W];     // [R3] [R16]
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // control, boot limit and threshold registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         ctrl2_q <= CTRL2_RST;
         boot_segment_limit_q <= BOOT_SEGMENT_LIMIT_RST;
         ipl_q   <= IPL_RST;
      end
      else if (ce && bus.wr)
      begin
         // one word per register, other addresses leave them alone
         ctrl2_q <= (bus.addr == CTRL2_ADDR) ?
                    (bus.wdata & (RD_W'(1) << CTRL2_ALT_EN_BIT)) : ctrl2_q;   // [R12]
         boot_segment_limit_q <= (bus.addr == BOOT_SEGMENT_LIMIT_ADDR) ? bus.wdata[BSL_W-1:0] : boot_segment_limit_q;   // [R13]
         ipl_q   <= (bus.addr == IPL_ADDR) ? bus.wdata[PRIO_W-1:0] : ipl_q;
      end
   end

   // ---------------------------------------------------------------
   // read port: data stands only in the cycle after the strobe
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         rdata_q <= '0;
      end
      else if (ce)
      begin
         rdata_q <= '0;
         if (bus.rd)
         begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
               if (32'(grp_word(bus.addr, FLAG_BASE, FLAG_WORDS)) == i / RD_W)
               begin
                  rdata_q[i % RD_W] <= flag_q[i];
               end
               if (32'(grp_word(bus.addr, ENABLE_BASE, FLAG_WORDS)) == i / RD_W)
               begin
                  rdata_q[i % RD_W] <= en_q[i];
               end
               if (32'(grp_word(bus.addr, PRIO_BASE, PRIO_WORDS)) == i / PRIO_PER_WORD)
               begin
                  rdata_q[(i % PRIO_PER_WORD)*4 +: PRIO_W] <= prio_q[i*PRIO_W +: PRIO_W];
               end
            end
            // single registers; unmapped addresses read zero
            if (bus.addr == CTRL2_ADDR)
            begin
               rdata_q <= ctrl2_q;
            end
            if (bus.addr == BOOT_SEGMENT_LIMIT_ADDR)
            begin
               rdata_q <= RD_W'(boot_segment_limit_q);
            end
            if (bus.addr == IPL_ADDR)
            begin
               rdata_q <= RD_W'(ipl_q);
            end
            if (bus.addr == STAT_ADDR)
            begin
               rdata_q <= {cpu_q.req, 3'h0, cpu_q.level, cpu_q.vec};   // [R17]
            end
         end
      end
   end

   assign rdata = rdata_q;

endmodule

// [tb/ivc_top_chk.sv]
// ivc_top_chk: port-level assertions for the interrupt vector controller
// assumes: one clock domain, ce held high by the bench
`timescale 1ns/100ps
module ivc_top_chk
   import ivc_pkg::*;
(
   // clock, reset, enable
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                ce,
   // register port
   input  wire ivc_bus_t            bus,
   input  wire logic [RD_W-1:0]     rdata,
   // requests and boot configuration
   input  wire logic [NUM_SRC-1:0]  irq_in,
   input  wire logic [NUM_TRAP-1:0] trap_in,
   input  wire logic                boot_segment_defined,
   input  wire logic                alt_table_config_select,
   // processor core
   input  wire ivc_cpu_t            cpu,
   input  wire logic                cpu_ack
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   ack_blank_a: assert property (cpu_ack && cpu.req |=> !cpu.req)
      else $error("request not dropped after acknowledge");
   trap_latency_a: assert property (
      (trap_in[0] && !cpu_ack) ##1 !cpu_ack |=> cpu.req && cpu.vec == 8'h00)
      else $error("trap 0 not presented two cycles after request");
   trap_level_a: assert property (
      cpu.req && cpu.vec < 8'h08 |-> cpu.level == TRAP_LEVEL && cpu.vec != 8'h07)
      else $error("trap presented with wrong level or reserved slot");
   user_level_a: assert property (
      cpu.req && cpu.vec >= 8'h08 |-> cpu.level inside {[4'h1:4'h7]} && cpu.vec <= 8'hfd)
      else $error("interrupt presented with bad level or vector");
   addr_offset_a: assert property (
      cpu.req |-> cpu.addr[10:0] == 11'h004 + {2'b00, cpu.vec, 1'b0})
      else $error("entry offset does not match vector");
   primary_base_a: assert property (
      cpu.req && !$past(boot_segment_defined && alt_table_config_select)
      |-> cpu.addr[23:11] == 13'h0000)
      else $error("alternate base used without its conditions");
   rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
      else $error("read data outside the read answer cycle");
   req_hold_a: assert property (
      cpu.req && !cpu_ack && !bus.wr && !$past(bus.wr) && irq_in == '0
      && $past(irq_in) == '0 && trap_in == '0 && $past(trap_in) == '0
      |=> cpu.req && $stable(cpu.vec) && $stable(cpu.level))
      else $error("presented vector changed without cause");
   // main scenarios reached
   trap_c: cover property (cpu_ack && cpu.req && cpu.vec < 8'h08);
   alt_c: cover property (cpu.req && cpu.addr[23:11] != 13'h0000);
   user_c: cover property (cpu_ack && cpu.req && cpu.vec >= 8'h08);
endmodule

bind ivc_top ivc_top_chk chk (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .bus(bus),
   .rdata(rdata), .irq_in(irq_in), .trap_in(trap_in),
   .boot_segment_defined(boot_segment_defined),
   .alt_table_config_select(alt_table_config_select), .cpu(cpu), .cpu_ack(cpu_ack));

// [tb/ivc_core_model.sv]
// ivc_core_model: processor core that accepts presented vectors
// assumes: bench sets stall and a response delay of 0 to 3 cycles
`timescale 1ns/100ps
module ivc_core_model
   import ivc_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // controller side
   input  wire ivc_cpu_t   cpu,
   output logic            cpu_ack,
   // bench controls
   input  wire logic       stall,
   input  wire logic [1:0] delay
);
   logic [1:0] wait_q;   // cycles the request has been seen
   // acknowledge once per presented vector, after the chosen delay
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         cpu_ack <= 1'b0;
         wait_q  <= 2'h0;
      end
      else if (cpu_ack)
      begin
         cpu_ack <= 1'b0;   // single pulse
         wait_q  <= 2'h0;
      end
      else if (cpu.req && !stall && wait_q >= delay)
         cpu_ack <= 1'b1;   // take the presented vector
      else if (cpu.req && wait_q != 2'h3)
         wait_q <= wait_q + 2'h1;   // slow core waits
   end
endmodule

// [tb/ivc_top_tb.sv]
// ivc_top_tb: self-checking bench with a reference arbiter model
// assumes: ivc_core_model acknowledges, ce held high
`timescale 1ns/100ps
module ivc_top_tb
   import ivc_pkg::*;
;
   logic ref_clk, nrst, ce, bsd, cfg, stall, cpu_ack;
   logic [1:0] delay;             // core response delay
   ivc_bus_t bus;                 // register port
   logic [RD_W-1:0] rdata;
   logic [NUM_SRC-1:0] irq_in;
   logic [NUM_TRAP-1:0] trap_in;
   ivc_cpu_t cpu;
   int failures, checks_done, seed, w;
   bit pend[NUM_SRC];             // model flags
   bit en[NUM_SRC];               // model enables
   int pr[NUM_SRC];               // model priorities
   bit tpend[NUM_TRAP];           // model trap latches
   logic [ADDR_W-1:0] base_exp;   // expected table base

   ivc_top dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .bus(bus), .rdata(rdata),
      .irq_in(irq_in), .trap_in(trap_in), .boot_segment_defined(bsd),
      .alt_table_config_select(cfg), .cpu(cpu), .cpu_ack(cpu_ack));
   ivc_core_model core (.ref_clk(ref_clk), .nrst(nrst), .cpu(cpu), .cpu_ack(cpu_ack),
      .stall(stall), .delay(delay));

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // traps first, then highest level, then lowest slot
   function automatic int winner();
      int b = -1;
      int bl = 0;
      for (int t = 0; t < 7; t++)
         if (tpend[t]) return t;
      for (int s = 0; s < NUM_SRC; s++)
         if (pend[s] && en[s] && pr[s] > bl)
         begin
            b = s + 8;
            bl = pr[s];
         end
      return b;
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bw(input logic [7:0] a, input logic [15:0] d);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic br(input logic [7:0] a, input logic [15:0] e);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1 check(rdata, e);
      @(posedge ref_clk);
   endtask

   // one-cycle hardware request pulse, mirrored in the model
   task automatic fire(input logic [NUM_SRC-1:0] v, input logic [NUM_TRAP-1:0] t);
      irq_in <= v;
      trap_in <= t;
      @(posedge ref_clk);
      irq_in <= '0;
      trap_in <= '0;
      for (int s = 0; s < NUM_SRC; s++)
         if (v[s]) pend[s] = 1;
      for (int k = 0; k < 7; k++)
         if (t[k]) tpend[k] = 1;
      @(posedge ref_clk);
   endtask

   // let the core take everything pending, then confirm idle
   task automatic drain();
      stall <= 1'b0;
      for (int i = 0; i < 600 && winner() >= 0; i++)
         @(posedge ref_clk);
      repeat (4) @(posedge ref_clk);
      stall <= 1'b1;
      check(cpu.req, 1'b0);
      check(winner(), -1);
   endtask

   // every acceptance compared with the model winner
   always @(posedge ref_clk)
      if (nrst && cpu_ack && cpu.req)
      begin
         w = winner();
         check(cpu.vec, w[7:0]);
         check(cpu.level, (w < 8) ? TRAP_LEVEL : pr[w-8][3:0]);
         check(cpu.addr, base_exp + 4 + 2 * w);
         if (w < 8) tpend[w] = 0;
         else pend[w-8] = 0;
      end

   task automatic summarize();
      $display("checks_done=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // watchdog
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      summarize();
   end

   initial
   begin
      logic [15:0] d;
      {nrst, bsd, cfg, delay} = '0;
      {ce, stall} = 2'b11;
      bus = '0;
      irq_in = '0;
      trap_in = '0;
      seed = 32'h6c6b;
      base_exp = '0;
      for (int s = 0; s < NUM_SRC; s++) pr[s] = 4;
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      // ----------------------------------------
      // reset values, unmapped and masked bits
      // ----------------------------------------
      bw(8'hff, 16'hffff);
      br(PRIO_BASE, 16'h4444);
      br(FLAG_BASE, 16'h0000);
      br(ENABLE_BASE, 16'h0000);
      br(BOOT_SEGMENT_LIMIT_ADDR, 16'h0000);
      br(8'hff, 16'h0000);
      bw(CTRL2_ADDR, 16'hffff);
      br(CTRL2_ADDR, 16'h8000);
      // ----------------------------------------
      // random rounds: levels, ties, software set
      // ----------------------------------------
      for (int r = 0; r < 6; r++)
      begin
         delay <= 2'($random(seed));
         for (int k = 0; k < 8; k++)
         begin
            d = 16'($random(seed)) & 16'h7777;
            bw(8'(PRIO_BASE + k), d);
            for (int j = 0; j < 4; j++) pr[4*k+j] = d[4*j +: 3];
         end
         for (int k = 0; k < 2; k++)
         begin
            d = 16'($random(seed));
            bw(8'(ENABLE_BASE + k), d);
            for (int b = 0; b < 16; b++) en[16*k+b] = d[b];
         end
         d = 16'($random(seed));
         bw(8'(FLAG_BASE + 1), d);
         for (int b = 0; b < 16; b++) pend[16+b] = d[b];
         fire({230'h0, 16'($random(seed))}, 8'h00);
         drain();
         for (int b = 0; b < 16; b++) d[b] = pend[b];
         br(FLAG_BASE, d);
         bw(FLAG_BASE, 16'h0000);
         bw(8'(FLAG_BASE + 1), 16'h0000);
         for (int b = 0; b < 32; b++) pend[b] = 0;
      end
      // ----------------------------------------
      // traps beat the top user level, unmasked
      // ----------------------------------------
      bw(ENABLE_BASE, 16'h0001);
      bw(PRIO_BASE, 16'h0007);
      for (int b = 0; b < 16; b++) en[b] = (b == 0);
      for (int b = 0; b < 4; b++) pr[b] = (b == 0) ? 7 : 0;
      fire(246'h1, 8'hff);
      drain();
      // ----------------------------------------
      // table selection over all three conditions
      // ----------------------------------------
      bw(BOOT_SEGMENT_LIMIT_ADDR, 16'h0003);
      br(BOOT_SEGMENT_LIMIT_ADDR, 16'h0003);
      for (int i = 0; i < 8; i++)
      begin
         bsd <= i[0];
         cfg <= i[1];
         bw(CTRL2_ADDR, {i[2], 15'h0000});
         base_exp = (i == 7) ? 24'h001800 : 24'h000000;
         fire(246'h1, 8'h04);
         repeat (2) @(posedge ref_clk);
         br(STAT_ADDR, 16'h8802);
         drain();
      end
      summarize();
   end
endmodule
